// *** src/frbg_pkg.sv ***
package frbg_pkg;

  // ----------------------------------------------------------------
  // Register indices on the register port
  // ----------------------------------------------------------------
  localparam logic [2:0] FRBG_IDX_LOW  = 3'h0;
  localparam logic [2:0] FRBG_IDX_HIGH = 3'h1;
  localparam logic [2:0] FRBG_IDX_FRAC = 3'h2;
  localparam logic [2:0] FRBG_IDX_MCR  = 3'h4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] FRBG_LOW_RST  = 8'h01;
  localparam logic [7:0] FRBG_HIGH_RST = 8'h00;
  localparam logic [7:0] FRBG_FRAC_RST = 8'h00;
  localparam logic       FRBG_PRE_RST  = 1'b0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FRBG_FRAC_LSB   = 0;
  localparam int FRBG_FRAC_W     = 4;
  localparam int FRBG_MODE_LSB   = 4;
  localparam int FRBG_MODE_W     = 2;
  localparam int FRBG_MCR_PRE_BIT = 7;

  // ----------------------------------------------------------------
  // Oversampling modes and their last sample index
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FRBG_OS16 = 2'b00,
    FRBG_OS8  = 2'b01,
    FRBG_OS4  = 2'b10,
    FRBG_OSRV = 2'b11
  } frbg_mode_t;

  localparam logic [3:0] FRBG_OS16_LAST = 4'hf;
  localparam logic [3:0] FRBG_OS8_LAST  = 4'h7;
  localparam logic [3:0] FRBG_OS4_LAST  = 4'h3;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  localparam logic [1:0] FRBG_PRE_LAST = 2'h3;

  // Path indices
  localparam int FRBG_TX = 0;
  localparam int FRBG_RX = 1;

endpackage

// *** src/frbg_sync.sv ***
`timescale 1ns/10ps
module frbg_sync
  import frbg_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic async_in,
  output logic      sync_out,
  output logic      rise_pulse
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic rise;
  } frbg_sync_t;

  frbg_sync_t q_r;
  frbg_sync_t q_nxt;

  // Meta flop only feeds the second flop
  always_comb
  begin
    q_nxt      = q_r;
    q_nxt.meta = async_in;
    q_nxt.sync = q_r.meta;
    q_nxt.prev = q_r.sync;
    q_nxt.rise = q_r.sync & ~q_r.prev;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      q_r <= '0;
    else
      q_r <= q_nxt;
  end

  assign sync_out   = q_r.sync;
  assign rise_pulse = q_r.rise;

endmodule

// *** src/frbg_prescale.sv ***
`timescale 1ns/10ps
module frbg_prescale
  import frbg_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic ref_tick,
  input  wire logic div4_sel,
  output logic      pre_tick
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] cnt;
    logic       div4;
    logic       tick;
  } frbg_pre_t;

  frbg_pre_t q_r;
  frbg_pre_t q_nxt;

  always_comb
  begin
    q_nxt      = q_r;
    q_nxt.tick = 1'b0;
    if (ref_tick)
    begin
      if (!q_r.div4 || q_r.cnt == FRBG_PRE_LAST)
      begin
        q_nxt.tick = 1'b1;
        q_nxt.cnt  = 2'h0;
        // Ratio change only at a whole output period
        q_nxt.div4 = div4_sel;
      end
      else
        q_nxt.cnt = q_r.cnt + 2'h1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q_r      <= '0;
      q_r.div4 <= FRBG_PRE_RST;
    end
    else
      q_r <= q_nxt;
  end

  assign pre_tick = q_r.tick;

endmodule

// *** src/frbg_top.sv ***
`timescale 1ns/10ps
module frbg_top
  import frbg_pkg::*;
#(
  parameter int NPATH = 2
)
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        osc_input_pin,
  output logic             osc_output_pin,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_path,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic [NPATH-1:0] samp_tick,
  output logic [NPATH-1:0] bit_tick
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] frac;
  } frbg_set_t;

  typedef struct packed {
    logic [16:0] cnt;
    logic [3:0]  acc;
    logic [3:0]  os_cnt;
    logic [15:0] act_int;
    logic [3:0]  act_frac;
    frbg_mode_t  act_mode;
    logic        samp;
    logic        bitt;
  } frbg_path_t;

  typedef struct packed {
    frbg_set_t  [NPATH-1:0] set;
    logic                   prescale;
    logic [7:0]             rdata;
    logic                   osc_fb;
    frbg_path_t [NPATH-1:0] path;
  } frbg_state_t;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  frbg_state_t      q_r;
  frbg_state_t      q_nxt;
  logic             osc_sync;
  logic             ref_tick;
  logic [NPATH-1:0] pre_tick;
  logic             wsel;
  logic [NPATH-1:0] wr_low;
  logic [NPATH-1:0] wr_high;
  logic [NPATH-1:0] wr_frac;
  logic             wr_ctrl;
  genvar            gp;

  assign wsel = reg_path;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------

  // Strobes come from ref_clk logic only, never from the reference pin
  generate
    for (gp = 0; gp < NPATH; gp++)
    begin : g_wdec
      assign wr_low[gp]  = reg_wr && reg_addr == FRBG_IDX_LOW && wsel == 1'(gp);
      assign wr_high[gp] = reg_wr && reg_addr == FRBG_IDX_HIGH && wsel == 1'(gp);
      assign wr_frac[gp] = reg_wr && reg_addr == FRBG_IDX_FRAC && wsel == 1'(gp);
    end
  endgenerate

  // One prescale bit serves both paths
  assign wr_ctrl = reg_wr && reg_addr == FRBG_IDX_MCR;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Zero integer part would stall; treat it as one
  function automatic logic [15:0] eff_int(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    if (v == 16'h0000)
      r = 16'h0001;
    return r;
  endfunction

  // Fraction accumulator step; bit 4 is the carry that stretches a period
  function automatic logic [4:0] frac_sum(
    input logic [3:0] acc,
    input logic [3:0] frac
  );
    logic [4:0] r;
    r = {1'b0, acc} + {1'b0, frac};
    return r;
  endfunction

  // Last count of a period: D-1, one more on a carry
  function automatic logic [16:0] period_last(
    input logic [15:0] ival,
    input logic        carry
  );
    logic [16:0] r;
    r = {1'b0, ival} - 17'h0_0001 + {16'h0000, carry};
    return r;
  endfunction

  // Last sample index of a bit; reserved code acts as 16X
  function automatic logic [3:0] os_last(input frbg_mode_t m);
    logic [3:0] r;
    r = FRBG_OS16_LAST;
    unique case (m)
      FRBG_OS16: r = FRBG_OS16_LAST;
      FRBG_OS8:  r = FRBG_OS8_LAST;
      FRBG_OS4:  r = FRBG_OS4_LAST;
      FRBG_OSRV: r = FRBG_OS16_LAST;
    endcase
    return r;
  endfunction

  // Register read mux
  function automatic logic [7:0] rd_mux(
    input frbg_set_t  s,
    input logic       pre,
    input logic [2:0] a
  );
    logic [7:0] r;
    r = 8'h00;
    if (a == FRBG_IDX_LOW)
      r = s.low;
    else if (a == FRBG_IDX_HIGH)
      r = s.high;
    else if (a == FRBG_IDX_FRAC)
      r = s.frac;
    else if (a == FRBG_IDX_MCR)
      r[FRBG_MCR_PRE_BIT] = pre;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Reference input
  // ----------------------------------------------------------------

  // Rising pin edges are the reference; a stopped pin leaves registers usable
  frbg_sync u_osc_sync (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .async_in   (osc_input_pin),
    .sync_out   (osc_sync),
    .rise_pulse (ref_tick)
  );

  // ----------------------------------------------------------------
  // Prescalers, one per path
  // ----------------------------------------------------------------
  // Shared control bit; each path still waits for its own wrap
  generate
    for (gp = 0; gp < NPATH; gp++)
    begin : g_pre
      frbg_prescale u_pre (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .ref_tick (ref_tick),
        .div4_sel (q_r.prescale),
        .pre_tick (pre_tick[gp])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [4:0]  sum;
    logic [16:0] last;
    logic [15:0] ival;
    sum   = 5'h00;
    last  = 17'h0_0000;
    ival  = 16'h0000;
    q_nxt = q_r;

    // Synchronized pin level echoed back inverted; only a stand-in for the oscillator output
    q_nxt.osc_fb = ~osc_sync;

    // Register port works from ref_clk alone
    for (int p = 0; p < NPATH; p++)
    begin
      if (wr_low[p])
        q_nxt.set[p].low = reg_wdata;
      if (wr_high[p])
        q_nxt.set[p].high = reg_wdata;
      if (wr_frac[p])
        q_nxt.set[p].frac = reg_wdata;
    end
    if (wr_ctrl)
      q_nxt.prescale = reg_wdata[FRBG_MCR_PRE_BIT];
    if (reg_rd)
      q_nxt.rdata = rd_mux(q_r.set[wsel], q_r.prescale, reg_addr);

    for (int p = 0; p < NPATH; p++)
    begin
      q_nxt.path[p].samp = 1'b0;
      q_nxt.path[p].bitt = 1'b0;
      // Fraction accumulator carry stretches this period by one
      sum  = frac_sum(q_r.path[p].acc, q_r.path[p].act_frac);
      ival = eff_int(q_r.path[p].act_int);
      last = period_last(ival, sum[4]);
      if (pre_tick[p])
      begin
        if (q_r.path[p].cnt >= last)
        begin
          q_nxt.path[p].samp = 1'b1;
          q_nxt.path[p].cnt  = 17'h0_0000;
          q_nxt.path[p].acc  = sum[3:0];
          // Bit boundary after 16, 8 or 4 samples
          if (q_r.path[p].os_cnt >= os_last(q_r.path[p].act_mode))
          begin
            q_nxt.path[p].bitt   = 1'b1;
            q_nxt.path[p].os_cnt = 4'h0;
          end
          else
            q_nxt.path[p].os_cnt = q_r.path[p].os_cnt + 4'h1;
          // New settings only at a period edge, so no runt pulse
          q_nxt.path[p].act_int  = {q_r.set[p].high, q_r.set[p].low};
          q_nxt.path[p].act_frac =
            q_r.set[p].frac[FRBG_FRAC_LSB +: FRBG_FRAC_W];
          q_nxt.path[p].act_mode =
            frbg_mode_t'(q_r.set[p].frac[FRBG_MODE_LSB +: FRBG_MODE_W]);
        end
        else
          q_nxt.path[p].cnt = q_r.path[p].cnt + 17'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Live copies reset too, so the first period already divides by one
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      q_r          <= '0;
      q_r.prescale <= FRBG_PRE_RST;
      for (int p = 0; p < NPATH; p++)
      begin
        q_r.set[p].low       <= FRBG_LOW_RST;
        q_r.set[p].high      <= FRBG_HIGH_RST;
        q_r.set[p].frac      <= FRBG_FRAC_RST;
        q_r.path[p].act_int  <= {FRBG_HIGH_RST, FRBG_LOW_RST};
        q_r.path[p].act_frac <= FRBG_FRAC_RST[FRBG_FRAC_LSB +: FRBG_FRAC_W];
        q_r.path[p].act_mode <= FRBG_OS16;
      end
    end
    else
      q_r <= q_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata      = q_r.rdata;
  assign osc_output_pin = q_r.osc_fb;

  // Ticks leave straight from flops, so they never glitch
  generate
    for (gp = 0; gp < NPATH; gp++)
    begin : g_out
      assign samp_tick[gp] = q_r.path[gp].samp;
      assign bit_tick[gp]  = q_r.path[gp].bitt;
    end
  endgenerate

endmodule

// *** bench/frbg_ref_src.sv ***
`timescale 1ns/10ps
module frbg_ref_src
(
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output logic            osc_input_pin
);
  // ------------------
  // External reference
  // ------------------
  logic [3:0] cnt_r;
  initial
  begin
    osc_input_pin = 1'b0;
    cnt_r = 4'h1;
  end
  // Stands low between bursts; half at least 2 so the sync flops see it
  always @(negedge ref_clk)
  begin
    if (!run)
    begin
      osc_input_pin <= 1'b0;
      cnt_r <= 4'h1;
    end
    else if (cnt_r >= half)
    begin
      osc_input_pin <= !osc_input_pin;
      cnt_r <= 4'h1;
    end
    else
      cnt_r <= cnt_r + 4'h1;
  end
endmodule

// *** bench/frbg_top_properties.sv ***
`timescale 1ns/10ps
module frbg_top_properties
  import frbg_pkg::*;
#(
  parameter int NPATH = 2
)
(
  input wire logic             ref_clk,
  input wire logic             srst,
  input wire logic             osc_input_pin,
  input wire logic             osc_output_pin,
  input wire logic             reg_wr,
  input wire logic             reg_rd,
  input wire logic             reg_path,
  input wire logic [2:0]       reg_addr,
  input wire logic [7:0]       reg_wdata,
  input wire logic [7:0]       reg_rdata,
  input wire logic [NPATH-1:0] samp_tick,
  input wire logic [NPATH-1:0] bit_tick
);
  // ------------------
  // Helper counters
  // ------------------
  logic       pin_q_r;
  logic [3:0] idle_r;
  logic [4:0] sc_r;
  always_ff @(posedge ref_clk)
  begin
    pin_q_r <= osc_input_pin;
    if (srst || (osc_input_pin && !pin_q_r))
      idle_r <= 4'h0;
    else if (idle_r != 4'hf)
      idle_r <= idle_r + 4'h1;
    if (srst || bit_tick[0])
      sc_r <= 5'h00;
    else if (samp_tick[0] && sc_r != 5'h1f)
      sc_r <= sc_r + 5'h01;
  end
  a_bit_in_samp: assert property (@(posedge ref_clk) disable iff (srst)
    (bit_tick & ~samp_tick) == '0) else $error("bit tick without sample tick");
  a_samp_pulse: assert property (@(posedge ref_clk) disable iff (srst)
    (samp_tick & $past(samp_tick)) == '0) else $error("sample tick longer than one cycle");
  a_bit_len: assert property (@(posedge ref_clk) disable iff (srst)
    bit_tick[0] |-> sc_r <= 5'h0f) else $error("bit longer than sixteen samples");
  // No reference edges, no ticks: the bus side never needs the reference
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (srst)
    idle_r >= 4'h8 |-> samp_tick == '0) else $error("tick without reference edge");
  a_rd_hold: assert property (@(posedge ref_clk) disable iff (srst)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without read");
  a_unmapped_rd: assert property (@(posedge ref_clk) disable iff (srst)
    reg_rd && (reg_addr == 3'h3 || reg_addr > 3'h4) |=> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  a_ctrl_rsvd: assert property (@(posedge ref_clk) disable iff (srst)
    reg_rd && reg_addr == FRBG_IDX_MCR |=> reg_rdata[6:0] == 7'h00)
    else $error("control low bits not zero");
  a_rst_quiet: assert property (@(posedge ref_clk)
    srst |=> samp_tick == '0 && bit_tick == '0 && reg_rdata == 8'h00)
    else $error("outputs active after reset");
endmodule
bind frbg_top frbg_top_properties #(.NPATH(NPATH)) frbg_top_properties_i (
  .ref_clk(ref_clk), .srst(srst), .osc_input_pin(osc_input_pin),
  .osc_output_pin(osc_output_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_path(reg_path), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .samp_tick(samp_tick), .bit_tick(bit_tick));

// *** bench/tb_frbg_top.sv ***
`timescale 1ns/10ps
module tb_frbg_top;
  import frbg_pkg::*;
  // ------------------
  // Bench
  // ------------------
  logic       ref_clk, srst, reg_wr, reg_rd, reg_path, run;
  logic       osc_input_pin, osc_output_pin;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] samp_tick, bit_tick;
  logic [3:0] half;
  int         errors, n_tests;
  int         cyc = 0;

  frbg_ref_src frbg_ref_src_i (.ref_clk(ref_clk), .run(run), .half(half),
    .osc_input_pin(osc_input_pin));
  frbg_top frbg_top_i (.ref_clk(ref_clk), .srst(srst), .osc_input_pin(osc_input_pin),
    .osc_output_pin(osc_output_pin), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_path(reg_path), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .samp_tick(samp_tick), .bit_tick(bit_tick));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Ceiling well above the few thousand cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input int p, input logic [2:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_path = p[0];
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input int p, input logic [2:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_path = p[0];
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk(16'(reg_rdata), 16'(e));
  endtask

  task automatic wait_bit(input int p);
    int c;
    c = 0;
    @(negedge ref_clk);
    while (bit_tick[p] !== 1'b1 && c < 5000)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask

  // Two bit ends first, so new settings are surely in force
  task automatic measure(input int p, input int exp_cyc, input int ratio);
    int c, s, b;
    c = 0;
    s = 0;
    b = 0;
    repeat (2) wait_bit(p);
    while (s < 16 && c < 5000)
    begin
      @(negedge ref_clk);
      c++;
      if (samp_tick[p] === 1'b1)
        s++;
      if (bit_tick[p] === 1'b1)
        b++;
    end
    chk(16'(c), 16'(exp_cyc));
    chk(16'(b), 16'(16 / ratio));
  endtask

  task automatic t_reset_regs();
    for (int p = 0; p < 2; p++)
    begin
      rd(p, FRBG_IDX_LOW, 8'h01);
      rd(p, FRBG_IDX_HIGH, 8'h00);
      rd(p, FRBG_IDX_FRAC, 8'h00);
    end
    rd(0, FRBG_IDX_MCR, 8'h00);
    rd(0, 3'h3, 8'h00);
    chk(16'(osc_output_pin), 16'h0001);
  endtask

  task automatic t_regs();
    wr(0, FRBG_IDX_LOW, 8'h27);
    wr(0, FRBG_IDX_HIGH, 8'ha5);
    wr(1, FRBG_IDX_LOW, 8'h9c);
    wr(1, FRBG_IDX_FRAC, 8'hf4);
    wr(0, 3'h3, 8'hff);
    wr(0, FRBG_IDX_MCR, 8'hff);
    rd(0, FRBG_IDX_LOW, 8'h27);
    rd(0, FRBG_IDX_HIGH, 8'ha5);
    rd(0, FRBG_IDX_FRAC, 8'h00);
    rd(1, FRBG_IDX_LOW, 8'h9c);
    rd(1, FRBG_IDX_HIGH, 8'h00);
    rd(1, FRBG_IDX_FRAC, 8'hf4);
    rd(0, 3'h3, 8'h00);
    rd(0, FRBG_IDX_MCR, 8'h80);
    wr(0, FRBG_IDX_MCR, 8'h00);
  endtask

  // Reference period 4 cycles: 16 samples span (16*D+frac)*pre*4 cycles
  task automatic t_rates();
    run <= 1'b1;
    wr(0, FRBG_IDX_LOW, 8'h03);
    wr(0, FRBG_IDX_HIGH, 8'h00);
    wr(0, FRBG_IDX_FRAC, 8'h05);
    wr(1, FRBG_IDX_LOW, 8'h02);
    wr(1, FRBG_IDX_FRAC, 8'h10);
    measure(0, 212, 16);
    measure(1, 128, 8);
    wr(0, FRBG_IDX_FRAC, 8'h20);
    wr(0, FRBG_IDX_MCR, 8'h80);
    measure(0, 768, 4);
    measure(1, 512, 8);
  endtask

  // 8X odd fraction, reserved mode as 16X, zero integer as one
  task automatic t_odd_modes();
    wr(0, FRBG_IDX_MCR, 8'h00);
    wr(0, FRBG_IDX_FRAC, 8'h15);
    wr(1, FRBG_IDX_LOW, 8'h00);
    wr(1, FRBG_IDX_FRAC, 8'h3a);
    measure(0, 212, 8);
    measure(1, 104, 16);
  endtask

  // Reset in mid-run brings back the divisor of one
  task automatic t_mid_reset();
    @(negedge ref_clk);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    rd(1, FRBG_IDX_LOW, 8'h01);
    rd(1, FRBG_IDX_FRAC, 8'h00);
    rd(0, FRBG_IDX_MCR, 8'h00);
    measure(1, 64, 16);
  endtask

  initial
  begin
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_path = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    run = 1'b0;
    half = 4'h2;
    errors = 0;
    n_tests = 0;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    t_reset_regs();
    t_regs();
    t_rates();
    t_odd_modes();
    t_mid_reset();
    report_and_stop();
  end
endmodule
